//--- cms_selector.sv
// Control method selector with V/F and flux vector command paths
`timescale 1ns/10ps
module cms_selector
  import cms_pkg::*;
(
  input  wire logic                      clk_in,        // 200 MHz clock
  input  wire logic                      reset_in,      // Sync reset
  input  wire logic                      setting_wr_in, // Setting write
  input  wire logic [1:0]                setting_sel_in, // Setting select
  input  wire logic [15:0]               setting_data_in, // Setting value
  input  wire logic                      run_in,        // Drive running
  input  wire logic [CMS_NUM_TERM-1:0]   term_level_in, // Terminal levels
  input  wire logic [CMS_NUM_TERM*8-1:0] term_func_in,  // Terminal funcs
  input  wire logic [15:0]               freq_in,       // Output frequency
  input  wire logic [15:0]               vf_gain_in,    // V/F ratio, Q8
  input  wire logic signed [15:0]        cur_a_in,      // Current alpha
  input  wire logic signed [15:0]        cur_b_in,      // Current beta
  input  wire logic signed [15:0]        cos_in,        // Flux cos, Q14
  input  wire logic signed [15:0]        sin_in,        // Flux sin, Q14
  input  wire logic signed [15:0]        comp_gain_in,  // Comp gain, Q8
  output cms_method_e                    method_out,    // Effective method
  output logic                           second_func_out, // Second set
  output logic                           setting_err_out, // Bad write
  output logic [15:0]                    volt_cmd_out,  // Voltage command
  output logic signed [15:0]             exc_cur_out,   // Excitation part
  output logic signed [15:0]             trq_cur_out    // Torque part
);
  logic [15:0]        capacity;
  logic [15:0]        poles;
  logic [15:0]        method_code;
  logic               vf_req;
  logic               wr_ok;
  cms_method_e        next_method;
  logic [31:0]        vf_prod;
  logic signed [31:0] p_ac;
  logic signed [31:0] p_bs;
  logic signed [31:0] p_as;
  logic signed [31:0] p_bc;
  logic signed [32:0] next_exc;
  logic signed [32:0] next_trq;
  logic signed [31:0] comp_prod;
  logic signed [17:0] next_volt;

  // Capacity or pole count left unspecified
  function automatic logic is_unspec(input logic [15:0] v);
    return v == CMS_UNSPEC;
  endfunction

  // Clamp a signed sum onto the unsigned voltage range
  function automatic logic [15:0] sat_volt(input logic signed [17:0] v);
    if (v < 0)
      return 16'h0000;
    else if (v > 18'sh0ffff)
      return 16'hffff;
    else
      return v[15:0];
  endfunction

  cms_vf_router u_router (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .term_level_in (term_level_in),
    .term_func_in  (term_func_in),
    .vf_req_out    (vf_req)
  );

  // Range check; out of range writes are dropped, not clipped
  always_comb
  begin
    case (setting_sel_in)
      CMS_SEL_CAP:
        wr_ok = is_unspec(setting_data_in) ||
                (setting_data_in >= CMS_CAP_MIN &&
                 setting_data_in <= CMS_CAP_MAX);
      CMS_SEL_POLE:
        wr_ok = is_unspec(setting_data_in) ||
                (setting_data_in != 16'h0000 && !setting_data_in[0] &&
                 setting_data_in <= CMS_POLE_MAX);
      CMS_SEL_CODE:
        wr_ok = setting_data_in == CMS_CODE_ADV ||
                setting_data_in == CMS_CODE_GP;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // Stored settings, defaults leave the motor unspecified
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      capacity    <= CMS_UNSPEC;
      poles       <= CMS_UNSPEC;
      method_code <= CMS_CODE_ADV;
    end
    else if (setting_wr_in && wr_ok)
    begin
      case (setting_sel_in)
        CMS_SEL_CAP:  capacity    <= setting_data_in;
        CMS_SEL_POLE: poles       <= setting_data_in;
        CMS_SEL_CODE: method_code <= setting_data_in;
        default:      capacity    <= capacity;
      endcase
    end
  end

  // Rejected write flag, one cycle per refused write
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      setting_err_out <= 1'b0;
    else
      setting_err_out <= setting_wr_in && !wr_ok;
  end

  // Method decode; unspecified motor or switchover wins over the code
  always_comb
  begin
    if (is_unspec(capacity) || is_unspec(poles))
      next_method = CMS_VF;
    else if (vf_req)
      next_method = CMS_VF;
    else if (method_code == CMS_CODE_GP)
      next_method = CMS_GP;
    else
      next_method = CMS_ADV;
  end

  // Method frozen while running so the motor model is never swapped live
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      method_out <= CMS_VF;
    else if (!run_in)
      method_out <= next_method;
  end

  // Second set follows the switchover even while running
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      second_func_out <= 1'b0;
    else
      second_func_out <= vf_req;
  end

  // Products; frequency times ratio and the rotation into flux axes
  assign vf_prod   = freq_in * vf_gain_in;
  assign p_ac      = cur_a_in * cos_in;
  assign p_bs      = cur_b_in * sin_in;
  assign p_as      = cur_a_in * sin_in;
  assign p_bc      = cur_b_in * cos_in;
  assign next_exc  = {p_ac[31], p_ac} + {p_bs[31], p_bs};
  assign next_trq  = {p_bc[31], p_bc} - {p_as[31], p_as};
  assign comp_prod = trq_cur_out * comp_gain_in;
  assign next_volt = $signed({2'b00, vf_prod[CMS_GAIN_FRAC +: 16]}) +
                     $signed({{2{comp_prod[31]}},
                              comp_prod[CMS_GAIN_FRAC +: 16]});

  // Current split; Q14 trig keeps one extra bit of headroom
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      exc_cur_out <= 16'sh0000;
      trq_cur_out <= 16'sh0000;
    end
    else
    begin
      exc_cur_out <= next_exc[CMS_TRIG_FRAC +: 16];
      trq_cur_out <= next_trq[CMS_TRIG_FRAC +: 16];
    end
  end

  // Voltage command; compensation only outside V/F
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      volt_cmd_out <= 16'h0000;
    else if (method_out == CMS_VF)
      volt_cmd_out <= vf_prod[CMS_GAIN_FRAC +: 16];
    else
      volt_cmd_out <= sat_volt(next_volt);
  end

  // Helper for checks: switchover level straight from the terminals
  logic sw_now;
  always_comb
  begin
    sw_now = 1'b0;
    for (int i = 0; i < CMS_NUM_TERM; i++)
    begin
      if (term_func_in[i*8 +: 8] == CMS_FUNC_VF && term_level_in[i])
        sw_now = 1'b1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_reset_gives_vf: assert property (
    $fell(reset_in) |-> method_out == CMS_VF && is_unspec(capacity) &&
                        is_unspec(poles) && method_code == CMS_CODE_ADV)
    else $error("reset did not leave V/F with unspecified motor");

  a_cap_range_kept: assert property (
    setting_wr_in && setting_sel_in == CMS_SEL_CAP &&
    setting_data_in > CMS_CAP_MAX && !is_unspec(setting_data_in)
    |=> capacity == $past(capacity))
    else $error("out of range capacity was stored");

  a_pole_write_takes: assert property (
    setting_wr_in && setting_sel_in == CMS_SEL_POLE &&
    setting_data_in == 16'h0004 |=> poles == 16'h0004)
    else $error("valid pole count not stored");

  a_unspec_forces_vf: assert property (
    !run_in && (is_unspec(capacity) || is_unspec(poles))
    |=> method_out == CMS_VF)
    else $error("unspecified motor did not give V/F");

  a_code_selects_gp: assert property (
    !run_in && !is_unspec(capacity) && !is_unspec(poles) && !vf_req &&
    method_code == CMS_CODE_GP |=> method_out == CMS_GP)
    else $error("code 30 did not give general-purpose vector");

  a_switch_forces_vf: assert property (
    sw_now ##1 (sw_now && !run_in) |=> method_out == CMS_VF)
    else $error("switchover did not force V/F");

  a_switch_second: assert property (
    sw_now |-> ##2 second_func_out)
    else $error("assigned terminal did not select second set");

  a_same_moment: assert property (
    $rose(second_func_out) && !$past(run_in) &&
    !is_unspec($past(capacity)) |-> method_out == CMS_VF)
    else $error("second set and V/F not selected together");

  a_run_holds_method: assert property (
    run_in [*2] |=> method_out == $past(method_out, 2))
    else $error("method changed while running");

  a_vf_voltage: assert property (
    method_out == CMS_VF |=> volt_cmd_out == $past(vf_prod[23:8]))
    else $error("V/F voltage not proportional to frequency");

  c_adv_selected: cover property (!run_in ##1 method_out == CMS_ADV);
  c_switch_in_run: cover property (run_in && sw_now ##2 second_func_out);
  c_gp_to_vf: cover property (method_out == CMS_GP ##[1:20]
                              method_out == CMS_VF);
  c_bad_write: cover property (setting_err_out);
endmodule // cms_selector

//--- cms_pkg.sv
// Constants and types shared by the control method selector
// Operation
// - A motor capacity from 0.1 to 15 kW is accepted, and 9999 means none is given, which gives V/F control.
// - A pole count of 2, 4, 6, 8 or 10 is accepted, and 9999 means none is given, which gives V/F control.
// - With both motor settings given, code 20 selects advanced flux vector, code 30 general-purpose flux vector, and 20 is the reset value.
// - If capacity or pole count holds 9999, V/F control is chosen whatever the method code is.
// - After reset V/F control is chosen because both motor settings start out unspecified.
// - While the switchover input is active and the drive is stopped, any flux vector method is replaced by V/F control.
// - The switchover function comes from an input terminal only when its function setting is 18.
// - When the switchover input asks for V/F, the second parameter set is chosen on the same edge as V/F control, two edges after the terminal level.
// - While running, the method never changes between V/F and flux vector, and a switchover only picks the second set.
// - In V/F control the voltage command is the output frequency times a fixed ratio.
// - In flux vector control the current is split into excitation and torque parts and the voltage is compensated by the torque part.
package cms_pkg;
  // Settings in 0.1 kW units for capacity, plain numbers otherwise
  localparam logic [15:0] CMS_UNSPEC     = 16'h270f; // 9999
  localparam logic [15:0] CMS_CAP_MIN    = 16'h0001; // 0.1 kW
  localparam logic [15:0] CMS_CAP_MAX    = 16'h0096; // 15.0 kW
  localparam logic [15:0] CMS_CODE_ADV   = 16'h0014; // 20
  localparam logic [15:0] CMS_CODE_GP    = 16'h001e; // 30
  localparam logic [15:0] CMS_POLE_MAX   = 16'h000a; // 10 poles
  localparam logic [7:0]  CMS_FUNC_VF    = 8'h12;    // 18
  localparam int          CMS_NUM_TERM   = 7;
  // Setting select codes for the write port
  localparam logic [1:0]  CMS_SEL_CAP    = 2'h0;
  localparam logic [1:0]  CMS_SEL_POLE   = 2'h1;
  localparam logic [1:0]  CMS_SEL_CODE   = 2'h2;
  // Fixed point positions
  localparam int          CMS_GAIN_FRAC  = 8;      // Q8 gains
  localparam int          CMS_TRIG_FRAC  = 14;     // Q14 sine/cosine

  typedef enum logic [1:0] {
    CMS_VF  = 2'b00,
    CMS_ADV = 2'b01,
    CMS_GP  = 2'b10
  } cms_method_e;
endpackage

//--- cms_vf_router.sv
// Routes the V/F switchover function from the assigned input terminals
`timescale 1ns/10ps
module cms_vf_router
  import cms_pkg::*;
(
  input  wire logic                        clk_in,       // System clock
  input  wire logic                        reset_in,     // Sync reset
  input  wire logic [CMS_NUM_TERM-1:0]     term_level_in, // Terminal levels
  input  wire logic [CMS_NUM_TERM*8-1:0]   term_func_in, // Function codes
  output logic                             vf_req_out    // Switchover active
);
  logic next_req;

  // Any terminal assigned to switchover and active raises the request
  always_comb
  begin
    next_req = 1'b0;
    for (int i = 0; i < CMS_NUM_TERM; i++)
    begin
      if (term_func_in[i*8 +: 8] == CMS_FUNC_VF && term_level_in[i])
      begin
        next_req = 1'b1;
      end
    end
  end

  // Registered so the method and parameter set see one common edge
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      vf_req_out <= 1'b0;
    else
      vf_req_out <= next_req;
  end
endmodule // cms_vf_router

//--- cms_term_driver.sv
// Controller model that drives the input terminal levels
`timescale 1ns/10ps
module cms_term_driver
  import cms_pkg::*;
(
  input  wire logic [CMS_NUM_TERM-1:0] drive_in,      // Contacts to close
  input  wire logic                    clk_in,        // System clock
  output logic [CMS_NUM_TERM-1:0]      term_level_out // Terminal levels
);
  // Contacts open at power-up so the block never sees an unknown level
  initial term_level_out = '0;

  // Contacts change one edge late, as a relay output of a controller would
  always @(posedge clk_in)
  begin
    term_level_out <= drive_in;
  end
endmodule // cms_term_driver

//--- control_method_selector_bench.sv
// Self-checking bench for the control method selector
`timescale 1ns/10ps
module control_method_selector_bench;
  import cms_pkg::*;
  logic                      clk_in, reset_in, setting_wr_in, run_in;
  logic [1:0]                setting_sel_in;
  logic [15:0]               setting_data_in, freq_in, vf_gain_in;
  logic signed [15:0]        cur_a_in, cur_b_in, cos_in, sin_in;
  logic signed [15:0]        comp_gain_in, exc_cur_out, trq_cur_out;
  logic [CMS_NUM_TERM-1:0]   drive, term_level_in;
  logic [CMS_NUM_TERM*8-1:0] term_func_in;
  cms_method_e               method_out;
  logic                      second_func_out, setting_err_out, err_seen;
  logic [15:0]               volt_cmd_out;
  int                        fail_count, check_count;

  cms_term_driver ctl (.drive_in(drive), .clk_in(clk_in),
                       .term_level_out(term_level_in));
  cms_selector dut (.clk_in(clk_in), .reset_in(reset_in),
    .setting_wr_in(setting_wr_in), .setting_sel_in(setting_sel_in),
    .setting_data_in(setting_data_in), .run_in(run_in),
    .term_level_in(term_level_in), .term_func_in(term_func_in),
    .freq_in(freq_in), .vf_gain_in(vf_gain_in), .cur_a_in(cur_a_in),
    .cur_b_in(cur_b_in), .cos_in(cos_in), .sin_in(sin_in),
    .comp_gain_in(comp_gain_in), .method_out(method_out),
    .second_func_out(second_func_out), .setting_err_out(setting_err_out),
    .volt_cmd_out(volt_cmd_out), .exc_cur_out(exc_cur_out),
    .trq_cur_out(trq_cur_out));

  // 200 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One write pulse; err stands only in the cycle after the taking edge
  task automatic wr_set(input logic [1:0] sel, input logic [15:0] data);
    @(posedge clk_in);
    setting_wr_in <= 1'b1;
    setting_sel_in <= sel;
    setting_data_in <= data;
    @(posedge clk_in);
    setting_wr_in <= 1'b0;
    #1 err_seen = setting_err_out;
    step(1);
    chk("err one cycle", 16'h0, 16'(setting_err_out));
    step(2);
  endtask

  // Method and second set settle within a few edges of any cause
  task automatic expect_sel(input cms_method_e m, input logic s);
    chk("method_out", 16'(m), 16'(method_out));
    chk("second_func_out", 16'(s), 16'(second_func_out));
  endtask

  task automatic scen_reset();
    expect_sel(CMS_VF, 1'b0);
    chk("volt_cmd_out", 16'h0200, volt_cmd_out);
    chk("exc_cur_out", 16'h1000, exc_cur_out);
    chk("trq_cur_out", 16'h0800, trq_cur_out);
  endtask

  task automatic scen_settings();
    wr_set(CMS_SEL_CAP, CMS_CAP_MAX);
    chk("err cap max", 16'h0, 16'(err_seen));
    expect_sel(CMS_VF, 1'b0);
    wr_set(CMS_SEL_POLE, 16'h0004);
    expect_sel(CMS_ADV, 1'b0);
    chk("volt flux", 16'h0a00, volt_cmd_out);
    wr_set(CMS_SEL_CODE, CMS_CODE_GP);
    expect_sel(CMS_GP, 1'b0);
    wr_set(CMS_SEL_CAP, 16'h0097);
    chk("err cap over", 16'h1, 16'(err_seen));
    expect_sel(CMS_GP, 1'b0);
    wr_set(CMS_SEL_POLE, 16'h0005);
    chk("err pole odd", 16'h1, 16'(err_seen));
    wr_set(CMS_SEL_POLE, CMS_UNSPEC);
    expect_sel(CMS_VF, 1'b0);
    wr_set(CMS_SEL_POLE, CMS_POLE_MAX);
    wr_set(CMS_SEL_CODE, CMS_CODE_ADV);
    expect_sel(CMS_ADV, 1'b0);
  endtask

  task automatic scen_switch();
    @(posedge clk_in);
    drive <= 7'h20;
    step(5);
    expect_sel(CMS_ADV, 1'b0);
    @(posedge clk_in);
    drive <= 7'h08;
    step(5);
    expect_sel(CMS_VF, 1'b1);
    @(posedge clk_in);
    drive <= 7'h00;
    step(5);
    expect_sel(CMS_ADV, 1'b0);
  endtask

  task automatic scen_run();
    @(posedge clk_in);
    run_in <= 1'b1;
    drive <= 7'h08;
    step(5);
    expect_sel(CMS_ADV, 1'b1);
    wr_set(CMS_SEL_CODE, CMS_CODE_GP);
    expect_sel(CMS_ADV, 1'b1);
    @(posedge clk_in);
    run_in <= 1'b0;
    step(3);
    expect_sel(CMS_VF, 1'b1);
    // Quarter turn of the flux angle exercises the sine products
    @(posedge clk_in);
    cos_in <= 16'sh0000;
    sin_in <= 16'sh4000;
    step(2);
    chk("exc rotated", 16'h0800, exc_cur_out);
    chk("trq rotated", 16'hf000, trq_cur_out);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence; terminal 3 carries switchover, terminal 5 another job
  initial
  begin
    fail_count = 0;
    check_count = 0;
    reset_in = 1'b1;
    setting_wr_in = 1'b0;
    setting_sel_in = 2'h3;
    setting_data_in = 16'h0000;
    run_in = 1'b0;
    drive = '0;
    term_func_in = {8'h00, 8'h03, 8'h00, CMS_FUNC_VF, 24'h000000};
    freq_in = 16'h0100;
    vf_gain_in = 16'h0200;
    cur_a_in = 16'sh1000;
    cur_b_in = 16'sh0800;
    cos_in = 16'sh4000;
    sin_in = 16'sh0000;
    comp_gain_in = 16'sh0100;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    step(3);
    scen_reset();
    scen_settings();
    scen_switch();
    scen_run();
    tally_and_finish();
  end
endmodule // control_method_selector_bench
